//--- pkg/rsc_pkg.sv
// Constants, field layouts and state codes of the reset source combiner
package rsc_pkg;

  // ==========================================================
  // Register byte offsets
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_RSTAT = 8'h04;
  localparam logic [7:0] ADDR_CSTAT = 8'h08;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h0c;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h10;
  localparam logic [7:0] ADDR_LIVE = 8'h14;

  // ==========================================================
  // Configuration register fields
  localparam int CTRL_W = 6;
  localparam int CTRL_LOW_POWER_BROWNOUT_RESET_EN = 0;
  localparam int CTRL_PIN_EN = 1;
  localparam int CTRL_LVP = 2;
  localparam int CTRL_STK_EN = 3;
  localparam int CTRL_POWER_UP_TIMER_SEL = 4;
  localparam int CTRL_SW_PULLUP = 5;
  // Low-power detector off, as from erased configuration
  localparam logic [5:0] CTRL_RESET = 6'h0a;

  // ==========================================================
  // Reset status register fields (flags 0..5 are active low)
  localparam int RSTAT_W = 8;
  localparam int RSTAT_POR_N = 0;
  localparam int RSTAT_BOR_N = 1;
  localparam int RSTAT_PIN_N = 2;
  localparam int RSTAT_SW_N = 3;
  localparam int RSTAT_WDT_N = 4;
  localparam int RSTAT_WWV_N = 5;
  localparam int RSTAT_STK_UNF = 6;
  localparam int RSTAT_STK_OVF = 7;
  localparam logic [7:0] RSTAT_POR_VAL = 8'h3c;

  // ==========================================================
  // Core status register fields
  localparam int CSTAT_W = 2;
  localparam int CSTAT_TO = 0;
  localparam int CSTAT_PD = 1;
  localparam logic [1:0] CSTAT_POR_VAL = 2'h3;

  // ==========================================================
  // Interrupt status and mask fields
  localparam int IRQ_W = 6;
  localparam int IRQ_POR = 0;
  localparam int IRQ_BOR = 1;
  localparam int IRQ_PIN = 2;
  localparam int IRQ_SW = 3;
  localparam int IRQ_WDT = 4;
  localparam int IRQ_STK = 5;

  // ==========================================================
  // Timing
  localparam int CLK_PERIOD_NS = 4;
  localparam int FILT_TIME_NS = 200;
  localparam int FILT_CYC = (FILT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int HOLD_CYC = 16;
  localparam int POWER_UP_TIMER_TIME_NS = 64000;
  localparam int POWER_UP_TIMER_CYC = POWER_UP_TIMER_TIME_NS / CLK_PERIOD_NS;
  localparam int TMR_W = 16;

  // ==========================================================
  // Reset sequencer states
  typedef enum logic [2:0] {
    ST_HOLD = 3'b001,
    ST_TIMER = 3'b010,
    ST_RUN = 3'b100
  } rsc_state_t;

endpackage : rsc_pkg

//--- core/rsc_pin_filter.sv
// Two-stage synchroniser and glitch filter for the external reset pin
`timescale 1ns/1ps
module rsc_pin_filter #(
  parameter int FILT_CYC = rsc_pkg::FILT_CYC,
  parameter int CW = 8
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Raw pin level and filtered level
  input wire logic pin_in,
  output logic pin_filt
);
  import rsc_pkg::*;

  logic meta_reg;
  logic sync_reg;
  logic filt_reg;
  logic [CW-1:0] stable_reg;
  logic [CW-1:0] stable_next;
  logic differs;

  // ==========================================================
  // Synchroniser; the pin idles high
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_reg <= 1'b1;
      sync_reg <= 1'b1;
    end else begin
      meta_reg <= pin_in;
      sync_reg <= meta_reg;
    end
  end

  // Filter: follow only a level that stays for FILT_CYC cycles
  assign differs = sync_reg != filt_reg;
  assign stable_next = differs ? stable_reg + CW'(1) : '0;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stable_reg <= '0;
      filt_reg <= 1'b1;
    end else if (differs && stable_reg == CW'(FILT_CYC - 1)) begin
      stable_reg <= '0;
      filt_reg <= sync_reg;
    end else begin
      stable_reg <= stable_next;
    end
  end

  assign pin_filt = filt_reg;

  // ==========================================================
  // Checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  AST_FILT_STABLE: assert property ($changed(filt_reg) |-> $past(stable_reg) == CW'(FILT_CYC - 1))
    else $error("filtered pin changed before the level was stable");

endmodule : rsc_pin_filter

//--- core/rsc_hold_timer.sv
// Loadable down-counter that keeps the reset sequencer waiting
`timescale 1ns/1ps
module rsc_hold_timer #(
  parameter int CW = rsc_pkg::TMR_W
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Load request and status
  input wire logic start,
  input wire logic [CW-1:0] load_val,
  output logic busy
);
  import rsc_pkg::*;

  logic [CW-1:0] cnt_reg;
  logic [CW-1:0] cnt_next;

  // Count down to zero, reload on start
  assign cnt_next = start ? load_val : (cnt_reg != '0 ? cnt_reg - CW'(1) : '0);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_reg <= '0;
    end else begin
      cnt_reg <= cnt_next;
    end
  end

  assign busy = cnt_reg != '0;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  AST_TMR_LOAD: assert property ((start && load_val > CW'(2)) |=> busy ##1 busy)
    else $error("timer not busy after load");

endmodule : rsc_hold_timer

//--- core/rsc_top.sv
// Reset source combiner: merges reset requests, records causes, APB registers
`timescale 1ns/1ps
module rsc_top #(
  parameter int POWER_UP_TIMER_CYC = rsc_pkg::POWER_UP_TIMER_CYC
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Supply monitors and mode (asynchronous levels)
  input wire logic por_req,
  input wire logic brownout_reset,
  input wire logic low_power_brownout_reset,
  input wire logic prog_mode,
  // External reset pin
  input wire logic external_reset_pin_in,
  output logic external_reset_pin_out,
  output logic external_reset_pin_oe,
  output logic weak_pullup_en,
  // Core events (one-cycle pulses, same clock)
  input wire logic wdt_timeout_evt,
  input wire logic wdt_window_evt,
  input wire logic wdt_clear_evt,
  input wire logic sw_reset_evt,
  input wire logic stack_overflow_evt,
  input wire logic stack_underflow_evt,
  // Results
  output logic chip_reset_n,
  output logic brownout_general,
  output logic irq
);
  import rsc_pkg::*;

  // ==========================================================
  // Declarations
  logic [3:0] meta_reg;
  logic [3:0] sync_reg;
  logic [3:0] async_in;
  logic por_s, bor_s, low_power_brownout_reset_s, prog_s;
  logic pin_filt;
  logic [CTRL_W-1:0] ctrl_reg;
  logic [RSTAT_W-1:0] rstat_reg;
  logic [RSTAT_W-1:0] rstat_next;
  logic [CSTAT_W-1:0] cstat_reg;
  logic [CSTAT_W-1:0] cstat_next;
  logic [IRQ_W-1:0] istat_reg;
  logic [IRQ_W-1:0] istat_next;
  logic [IRQ_W-1:0] imask_reg;
  logic [IRQ_W-1:0] ievt;
  logic [31:0] prdata_reg, rd_mux;
  logic pready_reg, pslverr_reg;
  logic chip_reset_n_reg, bor_gen_reg, irq_reg, pullup_reg, pin_oe_reg;
  logic prog_d_reg, bor_d_reg, pin_rst_d_reg, por_d_reg, power_up_timer_pend_reg;
  rsc_state_t state_reg, state_next;
  logic setup, access, wr_en, rd_done;
  logic hit_ctrl, hit_rstat, hit_cstat, hit_istat, hit_imask, hit_live, hit_any;
  logic cfg_low_power_brownout_reset_en, cfg_pin_en, cfg_stk_en, cfg_power_up_timer_sel;
  logic bor_gen, pin_en, pin_rst, prog_exit, por_evt, bor_evt, pin_evt;
  logic wdt_evt, stk_ovf, stk_unf, stk_evt, rst_lvl, rst_evt, pwr_lvl;
  logic tmr_start, tmr_busy;
  logic [TMR_W-1:0] tmr_load;

  // ==========================================================
  // Synchronisers for asynchronous levels
  assign async_in = {prog_mode, low_power_brownout_reset, brownout_reset, por_req};

  generate
    for (genvar i = 0; i < 4; i++) begin : g_sync
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          meta_reg[i] <= 1'b0;
          sync_reg[i] <= 1'b0;
        end else begin
          meta_reg[i] <= async_in[i];
          sync_reg[i] <= meta_reg[i];
        end
      end
    end
  endgenerate

  assign por_s = sync_reg[0];
  assign bor_s = sync_reg[1];
  assign low_power_brownout_reset_s = sync_reg[2];
  assign prog_s = sync_reg[3];

  // Filtered external reset pin
  rsc_pin_filter #(.FILT_CYC(FILT_CYC), .CW(8)) u_filter (
    .pclk(pclk),
    .presetn(presetn),
    .pin_in(external_reset_pin_in),
    .pin_filt(pin_filt)
  );

  // ==========================================================
  // Source combination
  assign cfg_low_power_brownout_reset_en = ctrl_reg[CTRL_LOW_POWER_BROWNOUT_RESET_EN];
  assign cfg_pin_en = ctrl_reg[CTRL_PIN_EN];
  assign cfg_stk_en = ctrl_reg[CTRL_STK_EN];
  assign cfg_power_up_timer_sel = ctrl_reg[CTRL_POWER_UP_TIMER_SEL];
  assign bor_gen = bor_s | (cfg_low_power_brownout_reset_en & low_power_brownout_reset_s);
  assign pin_en = ctrl_reg[CTRL_LVP] | cfg_pin_en;
  assign pin_rst = pin_en & ~pin_filt;
  assign prog_exit = prog_d_reg & ~prog_s;
  assign por_evt = (por_s & ~por_d_reg) | prog_exit;
  assign bor_evt = bor_gen & ~bor_d_reg;
  assign pin_evt = pin_rst & ~pin_rst_d_reg;
  assign wdt_evt = wdt_timeout_evt | wdt_window_evt;
  assign stk_ovf = cfg_stk_en & stack_overflow_evt;
  assign stk_unf = cfg_stk_en & stack_underflow_evt;
  assign stk_evt = stk_ovf | stk_unf;
  assign pwr_lvl = por_s | bor_gen | prog_s;
  assign rst_lvl = pwr_lvl | pin_rst;
  assign rst_evt = wdt_evt | sw_reset_evt | stk_evt | prog_exit;

  // Edge history
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prog_d_reg <= 1'b0;
      por_d_reg <= 1'b0;
      bor_d_reg <= 1'b0;
      pin_rst_d_reg <= 1'b0;
    end else begin
      prog_d_reg <= prog_s;
      por_d_reg <= por_s;
      bor_d_reg <= bor_gen;
      pin_rst_d_reg <= pin_rst;
    end
  end

  // ==========================================================
  // Reset sequencer
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_HOLD: begin
        if (!rst_lvl && !rst_evt && !tmr_busy) begin
          state_next = power_up_timer_pend_reg ? ST_TIMER : ST_RUN;
        end
      end
      ST_TIMER: begin
        if (rst_lvl || rst_evt) begin
          state_next = ST_HOLD;
        end else if (!tmr_busy && !tmr_start) begin
          state_next = ST_RUN;
        end
      end
      ST_RUN: begin
        if (rst_lvl || rst_evt) begin
          state_next = ST_HOLD;
        end
      end
      default: state_next = ST_HOLD;
    endcase
  end

  // Timer: short hold for pulse events, power-up delay after supply release
  assign tmr_start = rst_evt || (state_reg == ST_HOLD && state_next == ST_TIMER);
  assign tmr_load = rst_evt ? TMR_W'(HOLD_CYC) : TMR_W'(POWER_UP_TIMER_CYC);

  rsc_hold_timer #(.CW(TMR_W)) u_timer (
    .pclk(pclk),
    .presetn(presetn),
    .start(tmr_start),
    .load_val(tmr_load),
    .busy(tmr_busy)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= ST_HOLD;
      chip_reset_n_reg <= 1'b0;
      power_up_timer_pend_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      chip_reset_n_reg <= state_next == ST_RUN;
      if (pwr_lvl && cfg_power_up_timer_sel) begin
        power_up_timer_pend_reg <= 1'b1;
      end else if (state_next != ST_HOLD) begin
        power_up_timer_pend_reg <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Cause flags; hardware events win over a software write
  always_comb begin
    rstat_next = (wr_en && hit_rstat) ? pwdata[RSTAT_W-1:0] : rstat_reg;
    if (bor_evt) rstat_next[RSTAT_BOR_N] = 1'b0;
    if (pin_evt) rstat_next[RSTAT_PIN_N] = 1'b0;
    if (sw_reset_evt) rstat_next[RSTAT_SW_N] = 1'b0;
    if (wdt_evt) rstat_next[RSTAT_WDT_N] = 1'b0;
    if (wdt_window_evt) rstat_next[RSTAT_WWV_N] = 1'b0;
    if (stk_unf) rstat_next[RSTAT_STK_UNF] = 1'b1;
    if (stk_ovf) rstat_next[RSTAT_STK_OVF] = 1'b1;
    if (por_evt) rstat_next = RSTAT_POR_VAL;
  end

  // Core timeout and power-down flags
  always_comb begin
    cstat_next = (wr_en && hit_cstat) ? pwdata[CSTAT_W-1:0] : cstat_reg;
    if (wdt_clear_evt) cstat_next = CSTAT_POR_VAL;
    if (wdt_evt) cstat_next = 2'h2;
    if (por_evt) cstat_next = CSTAT_POR_VAL;
  end

  // Interrupt events, sticky; a read clears only the bits it returned, so a late event survives
  assign ievt = {stk_evt, wdt_evt, sw_reset_evt, pin_evt, bor_evt, por_evt};
  assign istat_next = (rd_done && hit_istat ? istat_reg & ~prdata_reg[IRQ_W-1:0] : istat_reg) | ievt;

  // ==========================================================
  // APB decode
  assign setup = psel & ~penable;
  assign access = psel & penable & pready_reg;
  assign wr_en = access & pwrite;
  assign rd_done = access & ~pwrite;
  assign hit_ctrl = paddr == ADDR_CTRL;
  assign hit_rstat = paddr == ADDR_RSTAT;
  assign hit_cstat = paddr == ADDR_CSTAT;
  assign hit_istat = paddr == ADDR_IRQ_STAT;
  assign hit_imask = paddr == ADDR_IRQ_MASK;
  assign hit_live = paddr == ADDR_LIVE;
  assign hit_any = hit_ctrl | hit_rstat | hit_cstat | hit_istat | hit_imask | hit_live;
  assign rd_mux = hit_ctrl ? {26'h0, ctrl_reg} :
                  hit_rstat ? {24'h0, rstat_reg} :
                  hit_cstat ? {30'h0, cstat_reg} :
                  hit_istat ? {26'h0, istat_reg} :
                  hit_imask ? {26'h0, imask_reg} :
                  hit_live ? {26'h0, state_reg, tmr_busy, pin_filt, chip_reset_n_reg} : 32'h0;

  // Bus answer: one wait-free access phase after each setup
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= 32'h0;
    end else begin
      pready_reg <= setup;
      pslverr_reg <= setup & ~hit_any;
      if (setup) prdata_reg <= pwrite ? 32'h0 : rd_mux;
    end
  end

  // Register file
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= CTRL_RESET;
      rstat_reg <= RSTAT_POR_VAL;
      cstat_reg <= CSTAT_POR_VAL;
      istat_reg <= '0;
      imask_reg <= '0;
    end else begin
      if (wr_en && hit_ctrl) ctrl_reg <= pwdata[CTRL_W-1:0];
      if (wr_en && hit_imask) imask_reg <= pwdata[IRQ_W-1:0];
      rstat_reg <= rstat_next;
      cstat_reg <= cstat_next;
      istat_reg <= istat_next;
    end
  end

  // ==========================================================
  // Pin pad and other outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pullup_reg <= 1'b1;
      pin_oe_reg <= 1'b0;
      bor_gen_reg <= 1'b0;
      irq_reg <= 1'b0;
    end else begin
      pullup_reg <= pin_en | ctrl_reg[CTRL_SW_PULLUP];
      pin_oe_reg <= 1'b0;
      bor_gen_reg <= bor_gen;
      irq_reg <= |(istat_next & imask_reg);
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign chip_reset_n = chip_reset_n_reg;
  assign brownout_general = bor_gen_reg;
  assign irq = irq_reg;
  assign weak_pullup_en = pullup_reg;
  assign external_reset_pin_oe = pin_oe_reg;
  assign external_reset_pin_out = 1'b0;

  // ==========================================================
  // Checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  AST_LOW_POWER_BROWNOUT_RESET_HOLD: assert property ((low_power_brownout_reset_s && cfg_low_power_brownout_reset_en) |=> !chip_reset_n)
    else $error("chip left reset during low-power brown-out");
  AST_LOW_POWER_BROWNOUT_RESET_OFF: assert property ((low_power_brownout_reset_s && !cfg_low_power_brownout_reset_en && !bor_s) |-> !bor_gen)
    else $error("disabled low-power detector reached brown-out");
  AST_BOR_FLAG: assert property ((bor_evt && !por_evt) |=> !rstat_reg[RSTAT_BOR_N] && brownout_general)
    else $error("brown-out did not clear its flag");
  AST_PIN_FLAG: assert property ((pin_evt && !por_evt) |=> !rstat_reg[RSTAT_PIN_N])
    else $error("pin reset did not clear its flag");
  AST_PIN_HOLD: assert property ((pin_en && !pin_filt) |=> !chip_reset_n)
    else $error("chip left reset while pin low");
  AST_PULLUP: assert property (pin_en |=> weak_pullup_en)
    else $error("pull-up off while pin function enabled");
  AST_NO_DRIVE: assert property (rst_evt |=> !external_reset_pin_oe [*4])
    else $error("internal reset drove the pin");
  AST_WDT: assert property ((wdt_timeout_evt && !por_evt) |=>
      !rstat_reg[RSTAT_WDT_N] && !cstat_reg[CSTAT_TO] && cstat_reg[CSTAT_PD] && !chip_reset_n)
    else $error("watchdog reset not recorded");
  AST_WWV: assert property ((wdt_window_evt && !por_evt) |=> !rstat_reg[RSTAT_WWV_N])
    else $error("window violation not recorded");
  AST_SW: assert property ((sw_reset_evt && !por_evt) |=> !rstat_reg[RSTAT_SW_N] ##0 !chip_reset_n [*8])
    else $error("software reset not applied");
  AST_STK: assert property ((stack_overflow_evt && cfg_stk_en && !por_evt) |=> rstat_reg[RSTAT_STK_OVF])
    else $error("stack overflow not recorded");
  AST_STK_OFF: assert property ((stack_overflow_evt && !cfg_stk_en && !por_evt && !(wr_en && hit_rstat))
      |=> rstat_reg[RSTAT_STK_OVF] == $past(rstat_reg[RSTAT_STK_OVF]))
    else $error("disabled stack reset changed its flag");
  AST_PROG_EXIT: assert property (prog_exit |=> rstat_reg == RSTAT_POR_VAL && !chip_reset_n)
    else $error("programming exit not handled as power-on");
  AST_POWER_UP_TIMER: assert property ((state_reg == ST_HOLD && state_next == ST_TIMER) |=> !chip_reset_n [*8])
    else $error("power-up timer did not hold reset");

  COV_PIN: cover property (pin_evt ##[1:100] chip_reset_n);
  COV_WDT: cover property (wdt_window_evt ##[1:50] chip_reset_n);
  COV_POWER_UP_TIMER: cover property (state_reg == ST_TIMER ##1 state_reg == ST_RUN);
  COV_IRQ: cover property (rd_done && hit_istat && irq);

endmodule : rsc_top

//--- tb/rsc_far_model.sv
// Far-side model: supply monitors and the external reset pin
`timescale 1ns/1ps
module rsc_far_model (
  // Clock
  input wire logic pclk,
  // Monitor levels and pin level
  output logic por_req,
  output logic brownout_reset,
  output logic low_power_brownout_reset,
  output logic prog_mode,
  output logic pin_level
);
  // Quiet supply; the board resistor holds the pin high when released
  initial begin
    {por_req, brownout_reset, low_power_brownout_reset, prog_mode, pin_level} = 5'h01;
  end
  // Change the monitor levels just after a clock edge
  task automatic levels(input logic [3:0] v);
    @(posedge pclk);
    {por_req, brownout_reset, low_power_brownout_reset, prog_mode} <= v;
  endtask : levels
  // Hold the pin low for n cycles, then release it to the pull-up
  task automatic press(input int n);
    @(posedge pclk);
    pin_level <= 1'b0;
    repeat (n) @(posedge pclk);
    pin_level <= ~pin_level; // Back to the pull-up level
  endtask : press
endmodule : rsc_far_model

//--- tb/testbench.sv
// Self-checking bench of the reset source combiner
`timescale 1ns/1ps
module testbench;
  import rsc_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic por, bor, lpb, prg, lvl, pin, pin_out, pin_oe, pull, crst_n, bog, irq, seen_rst;
  logic [5:0] evt;
  int failures, compares, cyc, n;
  // Pin wire from both parties
  assign pin = pin_oe ? pin_out : lvl;
  rsc_far_model i_far (.pclk(pclk), .por_req(por), .brownout_reset(bor), .low_power_brownout_reset(lpb),
    .prog_mode(prg), .pin_level(lvl));
  rsc_top #(.POWER_UP_TIMER_CYC(40)) i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .por_req(por), .brownout_reset(bor), .low_power_brownout_reset(lpb), .prog_mode(prg),
    .external_reset_pin_in(pin), .external_reset_pin_out(pin_out), .external_reset_pin_oe(pin_oe),
    .weak_pullup_en(pull), .wdt_timeout_evt(evt[0]), .wdt_window_evt(evt[1]), .wdt_clear_evt(evt[2]),
    .sw_reset_evt(evt[3]), .stack_overflow_evt(evt[4]), .stack_underflow_evt(evt[5]),
    .chip_reset_n(crst_n), .brownout_general(bog), .irq(irq));
  // ==========================================================
  // Clock, timeout and reset watcher
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cyc++;
    if (crst_n === 1'b0) seen_rst = 1'b1;
    if (cyc == 6000) begin
      failures++;
      complete_run();
    end
  end
  // ==========================================================
  // Shared tasks
  task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // One APB transfer, held until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    chk("pready", pready, 1);
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr
  task automatic rd(input string what, input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, '0);
    chk(what, q, exp);
  endtask : rd
  // One-cycle core event
  task automatic pulse(input int i);
    @(posedge pclk);
    evt <= 6'h01 << i;
    @(posedge pclk);
    evt <= '0;
  endtask : pulse
  // Wait for chip reset release, counting cycles in n
  task automatic settle();
    n = 0;
    do begin
      @(negedge pclk);
      n++;
    end while (crst_n !== 1'b1 && n < 300);
  endtask : settle
  // ==========================================================
  // Scenarios
  task automatic t_regs();
    rd("ctrl", ADDR_CTRL, 32'h0a);
    rd("rstat", ADDR_RSTAT, 32'h3c);
    rd("cstat", ADDR_CSTAT, 32'h03);
    apb(1'b0, 8'h18, '0);
    chk("unmapped", {q[0], e}, 1);
    chk("pin oe", {pin_out, pin_oe}, 0);
    chk("pullup", pull, 1);
    rd("live", ADDR_LIVE, 32'h23);
    $display("test regs done");
  endtask : t_regs
  task automatic t_sw();
    wr(ADDR_IRQ_MASK, 32'h08);
    pulse(3);
    @(negedge pclk);
    chk("sw reset", {crst_n, pin_oe}, 0);
    settle();
    chk("hold", n >= 12 && n <= 20, 1);
    chk("irq", irq, 1);
    rd("irq stat", ADDR_IRQ_STAT, 32'h08);
    rd("irq clr", ADDR_IRQ_STAT, 32'h00);
    chk("irq off", irq, 0);
    rd("sw flag", ADDR_RSTAT, 32'h34);
    $display("test sw done");
  endtask : t_sw
  task automatic t_wdt();
    wr(ADDR_IRQ_MASK, 32'h00);
    pulse(0);
    settle();
    chk("irq mask", irq, 0);
    rd("wdt to", ADDR_RSTAT, 32'h24);
    rd("cstat to", ADDR_CSTAT, 32'h02);
    pulse(2);
    rd("cstat clr", ADDR_CSTAT, 32'h03);
    wr(ADDR_RSTAT, 32'h3c);
    pulse(1);
    settle();
    rd("wdt wv", ADDR_RSTAT, 32'h0c);
    $display("test wdt done");
  endtask : t_wdt
  task automatic t_stk();
    pulse(4);
    settle();
    rd("ovf", ADDR_RSTAT, 32'h8c);
    wr(ADDR_CTRL, 32'h02);
    seen_rst = 1'b0;
    pulse(5);
    repeat (20) @(negedge pclk);
    chk("stk off", seen_rst, 0);
    rd("unf off", ADDR_RSTAT, 32'h8c);
    wr(ADDR_CTRL, 32'h0a);
    pulse(5);
    settle();
    rd("unf", ADDR_RSTAT, 32'hcc);
    $display("test stack done");
  endtask : t_stk
  task automatic t_pin();
    wr(ADDR_RSTAT, 32'h3c);
    seen_rst = 1'b0;
    i_far.press(20);
    repeat (70) @(negedge pclk);
    chk("glitch", seen_rst, 0);
    fork
      i_far.press(80);
      begin
        repeat (75) @(negedge pclk);
        chk("pin held", crst_n, 0);
      end
    join
    settle();
    rd("pin flag", ADDR_RSTAT, 32'h38);
    wr(ADDR_CTRL, 32'h08);
    repeat (2) @(negedge pclk);
    chk("pull off", pull, 0);
    wr(ADDR_CTRL, 32'h28);
    repeat (2) @(negedge pclk);
    chk("pull sw", pull, 1);
    seen_rst = 1'b0;
    i_far.press(80);
    repeat (60) @(negedge pclk);
    chk("pin off", seen_rst, 0);
    wr(ADDR_CTRL, 32'h0c);
    repeat (2) @(negedge pclk);
    chk("pull lvp", pull, 1);
    seen_rst = 1'b0;
    i_far.press(80);
    chk("pin lvp", seen_rst, 1);
    settle();
    $display("test pin done");
  endtask : t_pin
  task automatic t_bo();
    wr(ADDR_CTRL, 32'h08);
    seen_rst = 1'b0;
    i_far.levels(4'b0010);
    repeat (5) @(negedge pclk);
    chk("low_power_brownout_reset off", {bog, seen_rst}, 0);
    i_far.levels(4'b0000);
    wr(ADDR_CTRL, 32'h19);
    i_far.levels(4'b0010);
    repeat (5) @(negedge pclk);
    chk("low_power_brownout_reset on", {bog, crst_n}, 2);
    i_far.levels(4'b0000);
    settle();
    chk("power_up_timer", n >= 40 && n <= 60, 1);
    i_far.levels(4'b0100);
    repeat (5) @(negedge pclk);
    chk("bor", bog, 1);
    i_far.levels(4'b0000);
    settle();
    $display("test brownout done");
  endtask : t_bo
  task automatic t_prog();
    logic [3:0] v [2] = '{4'b1000, 4'b0001};
    foreach (v[i]) begin
      wr(ADDR_RSTAT, 32'hff);
      wr(ADDR_CSTAT, 32'h00);
      i_far.levels(v[i]);
      repeat (5) @(negedge pclk);
      i_far.levels(4'b0000);
      settle();
      rd("por rstat", ADDR_RSTAT, 32'h3c);
      rd("por cstat", ADDR_CSTAT, 32'h03);
    end
    $display("test prog done");
  endtask : t_prog
  // ==========================================================
  // Verdict and end of run
  task automatic complete_run();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : complete_run
  initial begin
    {presetn, psel, penable, pwrite, seen_rst} = 5'h0;
    paddr = '0;
    pwdata = '0;
    evt = '0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    settle();
    t_regs();
    t_sw();
    t_wdt();
    t_stk();
    t_pin();
    t_bo();
    t_prog();
    complete_run();
  end
endmodule : testbench
